/* dts_i2c_slave.sv */
// Notes on behaviour
// - first byte after START is slave address
// - type 1010b selects memory target
// - type 1101b selects registers, memory untouched
// - respond only when bits 2:1 match pins
// - bit 0 one reads, zero writes
// - memory writes carry two address bytes, 15-bit
// - reads start at latched address, kept
// - address increments after each byte, during the acknowledge bit
// - memory address wraps from last to zero
// - no limit on bytes per transaction
// - register target takes one address byte
// - register address above 18h gets NACK, abort
// - read: 8 bits out, ACK continues, NACK ends
// - write: 8 bits in, then acknowledge
// - all bytes shifted MSB first
// - commit after 8th bit; earlier START/STOP discards
// - no busy time, always acknowledges when addressed
// - read data starts right after slave address
// - repeated START abandons write, reads new address
// - register write uses one address byte
// - STOP aborts; START aborts and rearms
// - separate memory and register address latches
// - register reads auto-increment like memory
module dts_i2c_slave (
   input  wire logic        CLK_IN,
   input  wire logic        RST_N_IN,
   input  wire logic        SCL_IN,
   input  wire logic        SDA_IN,
   output logic             SDA_OUT,
   output logic             SDA_OE_N_OUT,
   input  wire logic [1:0]  SEL_IN,
   input  wire logic        SUPPLY_TRIP_IN,
   output logic [14:0]      MEM_ADDR_OUT,
   output logic [7:0]       MEM_WDATA_OUT,
   output logic             MEM_WE_OUT,
   input  wire logic [7:0]  MEM_RDATA_IN,
   output logic [4:0]       REG_ADDR_OUT,
   output logic [7:0]       REG_WDATA_OUT,
   output logic             REG_WE_OUT,
   input  wire logic [7:0]  REG_RDATA_IN,
   output logic             BUSY_OUT
);
   // ==========================================================
   // address increment helpers
   function automatic logic [14:0] mem_next(input logic [14:0] a);
      mem_next = (a == dts_pkg::MEM_LAST) ? dts_pkg::MEM_ADDR_RST : 15'(a + 15'h0001);
   endfunction

   function automatic logic [4:0] reg_next(input logic [4:0] a);
      reg_next = (a == dts_pkg::REG_LAST) ? dts_pkg::REG_ADDR_RST : 5'(a + 5'h01);
   endfunction

   // ==========================================================
   // line conditioning
   dts_line_if line ();

   dts_line_cond u_cond (
      .clk_in   (CLK_IN),
      .rst_n_in (RST_N_IN),
      .scl_in   (SCL_IN),
      .sda_in   (SDA_IN),
      .line     (line.cond)
   );

   // strap and supply pins, two flops before use
   logic [2:0] pin_sync1_q;
   logic [2:0] pin_sync2_q;
   logic [1:0] sel_s;
   logic       trip_s;

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         pin_sync1_q <= 3'h0;
         pin_sync2_q <= 3'h0;
      end else begin
         pin_sync1_q <= {SUPPLY_TRIP_IN, SEL_IN};
         pin_sync2_q <= pin_sync1_q;
      end
   end

   assign sel_s  = pin_sync2_q[1:0];
   assign trip_s = pin_sync2_q[2];

   // ==========================================================
   // state
   dts_pkg::dts_state_t state_q;
   dts_pkg::dts_role_t  role_q;
   logic [3:0]          cnt_q;
   logic [7:0]          rx_sh_q;
   logic [7:0]          tx_sh_q;
   logic [6:0]          addr_hi_q;
   logic [14:0]         mem_addr_q;
   logic [4:0]          reg_addr_q;
   logic                comp_q;
   logic                read_q;
   logic                mack_q;
   logic                sda_low_q;
   logic                mem_we_q;
   logic                reg_we_q;
   logic [7:0]          wdata_q;

   // ==========================================================
   // decode
   wire       byte_end   = line.scl_fall && (cnt_q == dts_pkg::BYTE_BITS);
   wire       rx_done    = (state_q == dts_pkg::ST_RX) && byte_end;
   wire [3:0] rx_type    = rx_sh_q[dts_pkg::TYPE_MSB:dts_pkg::TYPE_LSB];
   wire       type_mem   = (rx_type == dts_pkg::TYPE_MEM);
   wire       type_comp  = (rx_type == dts_pkg::TYPE_COMP);
   wire       sel_hit    = (rx_sh_q[dts_pkg::SEL_MSB:dts_pkg::SEL_LSB] == sel_s);
   wire       addr_hit   = (type_mem || type_comp) && sel_hit;
   wire       reg_bad    = (rx_sh_q > dts_pkg::REG_MAX);
   wire [7:0] rdata      = comp_q ? REG_RDATA_IN : MEM_RDATA_IN;
   wire       in_slave   = (role_q == dts_pkg::RL_SLAVE);

   // ==========================================================
   // byte sequencer
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         state_q    <= dts_pkg::ST_IDLE;
         role_q     <= dts_pkg::RL_SLAVE;
         cnt_q      <= dts_pkg::CNT_RST;
         rx_sh_q    <= 8'h00;
         tx_sh_q    <= 8'h00;
         addr_hi_q  <= 7'h00;
         mem_addr_q <= dts_pkg::MEM_ADDR_RST;
         reg_addr_q <= dts_pkg::REG_ADDR_RST;
         comp_q     <= 1'h0;
         read_q     <= 1'h0;
         mack_q     <= 1'h0;
         sda_low_q  <= 1'h0;
         mem_we_q   <= 1'h0;
         reg_we_q   <= 1'h0;
         wdata_q    <= 8'h00;
      end else begin
         mem_we_q <= 1'h0;
         reg_we_q <= 1'h0;
         if (mem_we_q) begin
            mem_addr_q <= mem_next(mem_addr_q);
         end
         if (reg_we_q) begin
            reg_addr_q <= reg_next(reg_addr_q);
         end
         if (trip_s) begin
            state_q    <= dts_pkg::ST_IDLE;
            mem_addr_q <= dts_pkg::MEM_ADDR_RST;
            sda_low_q  <= 1'h0;
         end else if (line.start) begin
            state_q   <= dts_pkg::ST_RX;
            role_q    <= dts_pkg::RL_SLAVE;
            cnt_q     <= dts_pkg::CNT_RST;
            sda_low_q <= 1'h0;
         end else if (line.stop) begin
            state_q   <= dts_pkg::ST_IDLE;
            sda_low_q <= 1'h0;
         end else begin
            case (state_q)
               dts_pkg::ST_RX: begin
                  if (line.scl_rise) begin
                     rx_sh_q <= {rx_sh_q[6:0], line.sda};
                     cnt_q   <= 4'(cnt_q + 4'h1);
                  end else if (byte_end) begin
                     cnt_q     <= dts_pkg::CNT_RST;
                     state_q   <= dts_pkg::ST_ACK;
                     sda_low_q <= 1'h1;
                     case (role_q)
                        dts_pkg::RL_SLAVE: begin
                           comp_q <= type_comp;
                           read_q <= rx_sh_q[dts_pkg::RW_BIT];
                           role_q <= type_comp ? dts_pkg::RL_REG_ADDR : dts_pkg::RL_ADDR_HI;
                           if (!addr_hit) begin
                              state_q   <= dts_pkg::ST_IDLE;
                              sda_low_q <= 1'h0;
                           end
                        end
                        dts_pkg::RL_ADDR_HI: begin
                           addr_hi_q <= rx_sh_q[6:0];
                           role_q    <= dts_pkg::RL_ADDR_LO;
                        end
                        dts_pkg::RL_ADDR_LO: begin
                           mem_addr_q <= {addr_hi_q, rx_sh_q};
                           role_q     <= dts_pkg::RL_DATA;
                        end
                        dts_pkg::RL_REG_ADDR: begin
                           role_q <= dts_pkg::RL_DATA;
                           if (reg_bad) begin
                              state_q   <= dts_pkg::ST_IDLE;
                              sda_low_q <= 1'h0;
                           end else begin
                              reg_addr_q <= rx_sh_q[4:0];
                           end
                        end
                        default: begin
                           wdata_q  <= rx_sh_q;
                           mem_we_q <= ~comp_q;
                           reg_we_q <= comp_q;
                        end
                     endcase
                  end
               end
               dts_pkg::ST_ACK: begin
                  if (line.scl_fall) begin
                     cnt_q <= dts_pkg::CNT_RST;
                     if (read_q) begin
                        state_q   <= dts_pkg::ST_TX;
                        tx_sh_q   <= rdata;
                        sda_low_q <= ~rdata[7];
                     end else begin
                        state_q   <= dts_pkg::ST_RX;
                        sda_low_q <= 1'h0;
                     end
                  end
               end
               dts_pkg::ST_TX: begin
                  if (line.scl_rise) begin
                     cnt_q <= 4'(cnt_q + 4'h1);
                  end else if (byte_end) begin
                     state_q   <= dts_pkg::ST_MACK;
                     sda_low_q <= 1'h0;
                     if (comp_q) begin
                        reg_addr_q <= reg_next(reg_addr_q);
                     end else begin
                        mem_addr_q <= mem_next(mem_addr_q);
                     end
                  end else if (line.scl_fall) begin
                     tx_sh_q   <= {tx_sh_q[6:0], 1'h0};
                     sda_low_q <= ~tx_sh_q[6];
                  end
               end
               dts_pkg::ST_MACK: begin
                  if (line.scl_rise) begin
                     mack_q <= ~line.sda;
                  end else if (line.scl_fall) begin
                     cnt_q <= dts_pkg::CNT_RST;
                     if (mack_q) begin
                        state_q   <= dts_pkg::ST_TX;
                        tx_sh_q   <= rdata;
                        sda_low_q <= ~rdata[7];
                     end else begin
                        state_q <= dts_pkg::ST_IDLE;
                     end
                  end
               end
               default: begin
                  sda_low_q <= 1'h0;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // outputs
   assign SDA_OUT       = 1'h0;
   assign SDA_OE_N_OUT  = ~sda_low_q;
   assign MEM_ADDR_OUT  = mem_addr_q;
   assign REG_ADDR_OUT  = reg_addr_q;
   assign MEM_WDATA_OUT = wdata_q;
   assign REG_WDATA_OUT = wdata_q;
   assign MEM_WE_OUT    = mem_we_q;
   assign REG_WE_OUT    = reg_we_q;
   assign BUSY_OUT      = (state_q != dts_pkg::ST_IDLE);

   // ==========================================================
   // checks
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RST_N_IN);

   AST_SLAVE_MISS: assert property (
      (rx_done && in_slave && !line.start && !line.stop && !trip_s && !sel_hit)
         |=> (state_q == dts_pkg::ST_IDLE) && !sda_low_q)
      else $error("slave address with wrong select was acknowledged");

   AST_COMP_NO_MEM: assert property (
      mem_we_q |-> !comp_q)
      else $error("register target wrote the memory");

   AST_REG_BAD_NACK: assert property (
      (rx_done && (role_q == dts_pkg::RL_REG_ADDR) && reg_bad && !line.start && !line.stop && !trip_s)
         |=> (state_q == dts_pkg::ST_IDLE) ##1 !sda_low_q)
      else $error("illegal register address not refused");

   AST_MEM_WRAP: assert property (
      (mem_we_q && (mem_addr_q == dts_pkg::MEM_LAST) && !trip_s) |=> (mem_addr_q == dts_pkg::MEM_ADDR_RST))
      else $error("memory address did not wrap to zero");

   AST_WRITE_INC: assert property (
      (mem_we_q && !trip_s) |=> (mem_addr_q == mem_next($past(mem_addr_q))))
      else $error("memory address not advanced after a write");

   AST_ACK_HELD: assert property (
      $rose(state_q == dts_pkg::ST_ACK) |-> sda_low_q)
      else $error("acknowledge not driven after received byte");

   AST_WE_ON_8TH: assert property (
      (mem_we_q || reg_we_q) |-> $past(rx_done) && (state_q == dts_pkg::ST_ACK))
      else $error("write strobe outside the eighth bit");

   AST_START_ABORT: assert property (
      (line.start && !trip_s)
         |=> (state_q == dts_pkg::ST_RX) && (role_q == dts_pkg::RL_SLAVE) && (cnt_q == dts_pkg::CNT_RST))
      else $error("START did not rearm the address phase");

   AST_STOP_IDLE: assert property (
      (line.stop && !line.start && !trip_s) |=> (state_q == dts_pkg::ST_IDLE) && !sda_low_q)
      else $error("STOP did not end the transfer");

   AST_TX_MSB: assert property (
      ($rose(state_q == dts_pkg::ST_TX)) |-> (sda_low_q == ~tx_sh_q[7]))
      else $error("read byte not started with its top bit");

   AST_NACK_END: assert property (
      (state_q == dts_pkg::ST_MACK && line.scl_fall && !mack_q && !line.start && !line.stop && !trip_s)
         |=> (state_q == dts_pkg::ST_IDLE) [*2])
      else $error("read continued after not-acknowledge");

   COV_MEM_WRITE: cover property (mem_we_q);
   COV_REG_WRITE: cover property (reg_we_q);
   COV_READ_ACKED: cover property ((state_q == dts_pkg::ST_MACK) && line.scl_fall && mack_q);
   COV_REG_REFUSED: cover property (rx_done && (role_q == dts_pkg::RL_REG_ADDR) && reg_bad);
endmodule

/* dts_pkg.sv */
package dts_pkg;
   // ==========================================================
   // slave address decode
   localparam logic [3:0] TYPE_MEM       = 4'hA;
   localparam logic [3:0] TYPE_COMP      = 4'hD;
   localparam int         TYPE_MSB       = 7;
   localparam int         TYPE_LSB       = 4;
   localparam int         SEL_MSB        = 2;
   localparam int         SEL_LSB        = 1;
   localparam int         RW_BIT         = 0;

   // ==========================================================
   // address latches
   localparam int         MEM_AW         = 15;
   localparam int         REG_AW         = 5;
   localparam logic [14:0] MEM_LAST      = 15'h7FFF;
   localparam logic [14:0] MEM_ADDR_RST  = 15'h0000;
   localparam logic [4:0] REG_ADDR_RST   = 5'h00;
   localparam logic [7:0] REG_MAX        = 8'h18;
   localparam logic [4:0] REG_LAST       = 5'h18;

   // ==========================================================
   // bit sequencing
   localparam logic [3:0] BYTE_BITS      = 4'h8;
   localparam logic [3:0] CNT_RST        = 4'h0;
   localparam int         SYNC_STAGES    = 2;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RX,
      ST_ACK,
      ST_TX,
      ST_MACK
   } dts_state_t;

   typedef enum logic [2:0] {
      RL_SLAVE,
      RL_ADDR_HI,
      RL_ADDR_LO,
      RL_REG_ADDR,
      RL_DATA
   } dts_role_t;
endpackage

/* dts_line_if.sv */
interface dts_line_if;
   logic scl_rise;
   logic scl_fall;
   logic sda;
   logic start;
   logic stop;

   modport cond (output scl_rise, output scl_fall, output sda, output start, output stop);
   modport core (input  scl_rise, input  scl_fall, input  sda, input  start, input  stop);
endinterface

/* dts_line_cond.sv */
module dts_line_cond (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic scl_in,
   input  wire logic sda_in,
   dts_line_if.cond  line
);
   // ==========================================================
   // two-stage synchronisers, then one history stage
   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic       scl_prev_q;
   logic       sda_prev_q;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_prev_q <= 1'h1;
         sda_prev_q <= 1'h1;
      end else begin
         scl_sync_q <= {scl_sync_q[0], scl_in};
         sda_sync_q <= {sda_sync_q[0], sda_in};
         scl_prev_q <= scl_sync_q[1];
         sda_prev_q <= sda_sync_q[1];
      end
   end

   // ==========================================================
   // edge and bus condition detection
   assign line.sda      = sda_sync_q[1];
   assign line.scl_rise = scl_sync_q[1] & ~scl_prev_q;
   assign line.scl_fall = ~scl_sync_q[1] & scl_prev_q;
   assign line.start    = scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_sync_q[1];
   assign line.stop     = scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_sync_q[1];
endmodule

/* dts_bus_master.sv */
module dts_bus_master (
   output logic      scl_out,
   output logic      sda_low_out,
   input  wire logic sda_in
);
   timeunit 1ns;
   timeprecision 1ns;

   // scl stands high between frames; sda is released to its pull-up
   initial begin
      scl_out     = 1'b1;
      sda_low_out = 1'b0;
   end

   // ==========================================
   // bus clock: low 500 ns, high 300 ns
   task automatic bit_clk(input logic v, output logic r);
      #200 sda_low_out = ~v;
      #300 scl_out = 1'b1;
      #200 r = sda_in;
      #100 scl_out = 1'b0;
   endtask

   task automatic start_cond();
      #200 sda_low_out = 1'b0;
      #300 scl_out = 1'b1;
      #150 sda_low_out = 1'b1;
      #150 scl_out = 1'b0;
   endtask

   task automatic stop_cond();
      #200 sda_low_out = 1'b1;
      #300 scl_out = 1'b1;
      #150 sda_low_out = 1'b0;
      #650;
   endtask

   // ==========================================
   // n bits msb first, then the ack clock when the byte is whole
   task automatic send(input logic [7:0] b, input int n, output logic ack);
      logic r;
      for (int i = 7; i > 7 - n; i--) begin
         bit_clk(b[i], r);
      end
      ack = 1'b0;
      if (n == 8) begin
         bit_clk(1'b1, r);
         ack = ~r;
      end
   endtask

   // last byte of a read gets a nack, then the caller issues stop
   task automatic recv(input logic ack, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_clk(1'b1, r);
         b[i] = r;
      end
      bit_clk(~ack, r);
   endtask
endmodule

/* test_dual_target_i2c_slave_access.sv */
module test_dual_target_i2c_slave_access;
   timeunit 1ns;
   timeprecision 1ns;

   localparam logic [1:0] PINS = 2'h2;

   logic        clk_in;
   logic        rst_n;
   logic        scl;
   logic        m_low;
   logic        sda_wire;
   logic        sda_out;
   logic        sda_oe_n;
   logic        trip;
   logic        mem_we;
   logic        reg_we;
   logic        busy;
   logic        ack;
   logic [1:0]  sel;
   logic [14:0] mem_addr;
   logic [14:0] exp_mptr;
   logic [14:0] a;
   logic [4:0]  reg_addr;
   logic [4:0]  exp_rptr;
   logic [7:0]  mem_wdata;
   logic [7:0]  reg_wdata;
   logic [7:0]  mem [0:32767];
   logic [7:0]  ref_mem [0:32767];
   logic [7:0]  regs [0:31];
   logic [7:0]  ref_reg [0:31];
   int          n_mismatch = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   int          n;

   // open drain wire with pull-up
   assign sda_wire = (sda_oe_n === 1'b0 ? sda_out : 1'b1) & ~m_low;

   dts_i2c_slave i_dts_i2c_slave (
      .CLK_IN        (clk_in),
      .RST_N_IN      (rst_n),
      .SCL_IN        (scl),
      .SDA_IN        (sda_wire),
      .SDA_OUT       (sda_out),
      .SDA_OE_N_OUT  (sda_oe_n),
      .SEL_IN        (sel),
      .SUPPLY_TRIP_IN(trip),
      .MEM_ADDR_OUT  (mem_addr),
      .MEM_WDATA_OUT (mem_wdata),
      .MEM_WE_OUT    (mem_we),
      .MEM_RDATA_IN  (mem[mem_addr]),
      .REG_ADDR_OUT  (reg_addr),
      .REG_WDATA_OUT (reg_wdata),
      .REG_WE_OUT    (reg_we),
      .REG_RDATA_IN  (regs[reg_addr]),
      .BUSY_OUT      (busy)
   );

   dts_bus_master i_dts_bus_master (
      .scl_out    (scl),
      .sda_low_out(m_low),
      .sda_in     (sda_wire)
   );

   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   always @(posedge clk_in) begin
      if (mem_we === 1'b1) begin
         mem[mem_addr] <= mem_wdata;
      end
      if (reg_we === 1'b1) begin
         regs[reg_addr] <= reg_wdata;
      end
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_mismatch++;
         print_verdict();
      end
   end

   // ==========================================
   // checking
   task automatic print_verdict();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string what);
      chk8({7'h00, got}, {7'h00, exp}, what);
   endtask

   function automatic logic [14:0] mem_next(input logic [14:0] p);
      return p + 15'h0001;
   endfunction

   function automatic logic [4:0] reg_next(input logic [4:0] p);
      return (p == dts_pkg::REG_LAST) ? 5'h00 : p + 5'h01;
   endfunction

   // ==========================================
   // bus transactions
   task automatic head(input logic [3:0] kind, input logic rw, input logic exp_ack);
      i_dts_bus_master.start_cond();
      i_dts_bus_master.send({kind, 1'b0, PINS, rw}, 8, ack);
      chk1(ack, exp_ack, "slave address ack");
   endtask

   task automatic put(input logic [7:0] b, input logic exp_ack);
      i_dts_bus_master.send(b, 8, ack);
      chk1(ack, exp_ack, "byte ack");
   endtask

   task automatic mem_load(input logic [14:0] p);
      head(dts_pkg::TYPE_MEM, 1'b0, 1'b1);
      put({1'($urandom), p[14:8]}, 1'b1);
      put(p[7:0], 1'b1);
      exp_mptr = p;
   endtask

   task automatic reg_load(input logic [7:0] p, input logic ok);
      head(dts_pkg::TYPE_COMP, 1'b0, 1'b1);
      put(p, ok);
      if (ok) begin
         exp_rptr = p[4:0];
      end
   endtask

   task automatic write_run(input logic to_mem, input int cnt);
      logic [7:0] d;
      for (int i = 0; i < cnt; i++) begin
         d = 8'($urandom);
         put(d, 1'b1);
         if (to_mem) begin
            ref_mem[exp_mptr] = d;
            exp_mptr = mem_next(exp_mptr);
         end else begin
            ref_reg[exp_rptr] = d;
            exp_rptr = reg_next(exp_rptr);
         end
      end
      i_dts_bus_master.stop_cond();
   endtask

   task automatic read_cur(input logic [3:0] kind, input int cnt);
      logic [7:0] b;
      head(kind, 1'b1, 1'b1);
      for (int i = 0; i < cnt; i++) begin
         i_dts_bus_master.recv(i < cnt - 1, b);
         if (kind == dts_pkg::TYPE_MEM) begin
            chk8(b, ref_mem[exp_mptr], "memory read");
            exp_mptr = mem_next(exp_mptr);
         end else begin
            chk8(b, ref_reg[exp_rptr], "register read");
            exp_rptr = reg_next(exp_rptr);
         end
      end
      i_dts_bus_master.stop_cond();
   endtask

   // ==========================================
   // main sequence
   initial begin
      void'($urandom(76510));
      rst_n = 1'b0;
      sel = PINS;
      trip = 1'b0;
      for (int i = 0; i < 32768; i++) begin
         mem[i] = 8'(i * 7);
         ref_mem[i] = 8'(i * 7);
      end
      for (int i = 0; i < 32; i++) begin
         regs[i] = 8'(i * 3);
         ref_reg[i] = 8'(i * 3);
      end
      repeat (4) @(posedge clk_in);
      #1 rst_n = 1'b1;
      repeat (4) @(posedge clk_in);
      #1;
      repeat (4) begin
         a = 15'($urandom);
         n = 1 + $urandom % 6;
         mem_load(a);
         write_run(1'b1, n);
         mem_load(a);
         read_cur(dts_pkg::TYPE_MEM, n);
         read_cur(dts_pkg::TYPE_MEM, 2);
      end
      mem_load(15'h7FF6);
      write_run(1'b1, 20);
      mem_load(15'h7FF6);
      read_cur(dts_pkg::TYPE_MEM, 20);
      for (int t = 0; t < 16; t++) begin
         head(4'(t), 1'b0, 4'(t) == dts_pkg::TYPE_MEM || 4'(t) == dts_pkg::TYPE_COMP);
         i_dts_bus_master.stop_cond();
      end
      for (int s = 0; s < 4; s++) begin
         @(posedge clk_in);
         #1 sel = 2'(s);
         head(dts_pkg::TYPE_MEM, 1'b0, 2'(s) == PINS);
         i_dts_bus_master.stop_cond();
      end
      @(posedge clk_in);
      #1 sel = PINS;
      reg_load(8'h17, 1'b1);
      write_run(1'b0, 2);
      reg_load(8'h19, 1'b0);
      put(8'h5A, 1'b0);
      i_dts_bus_master.stop_cond();
      reg_load(8'hFF, 1'b0);
      i_dts_bus_master.stop_cond();
      reg_load(8'h16, 1'b1);
      read_cur(dts_pkg::TYPE_COMP, 4);
      read_cur(dts_pkg::TYPE_MEM, 2);
      // byte cut by stop, then by a repeated start
      mem_load(15'h0100);
      i_dts_bus_master.send(8'hC3, 5, ack);
      i_dts_bus_master.stop_cond();
      read_cur(dts_pkg::TYPE_MEM, 1);
      mem_load(15'h0200);
      i_dts_bus_master.send(8'h3C, 7, ack);
      read_cur(dts_pkg::TYPE_MEM, 1);
      // supply trip clears only the memory latch
      @(posedge clk_in);
      #1 trip = 1'b1;
      repeat (6) @(posedge clk_in);
      #1 trip = 1'b0;
      repeat (6) @(posedge clk_in);
      exp_mptr = 15'h0000;
      read_cur(dts_pkg::TYPE_MEM, 2);
      read_cur(dts_pkg::TYPE_COMP, 1);
      chk1(busy, 1'b0, "busy after stop");
      for (int i = 0; i < 32768; i++) begin
         chk8(mem[i], ref_mem[i], "memory array");
      end
      for (int i = 0; i < 32; i++) begin
         chk8(regs[i], ref_reg[i], "register file");
      end
      print_verdict();
   end
endmodule
